// File: hw/bcp_core.v
// Purpose: Checksums, hex record loading and password check for serial boot
// Assumes: Byte streams and memory port are on clk_sys_in; read data valid
//          in the cycle after mem_rd_out is high
// Notes:   Any error parks the block until reset
`timescale 1ns/1ps
`include "bcp_map.vh"

// What this block does
// - Return a checksum after erase, write, sum, read, RAM load, identity, status.
// - Checksum adds covered bytes one at a time into a word.
// - Erase sums whole flash after chip erase, erased region after sector.
// - Write sums whole flash range, record framing fields excluded.
// - Read sums only the flash bytes read out.
// - RAM load sums RAM from first to last received address.
// - Identity sums transferred bytes 9 to 18; status bytes 9 to 12.
// - After a record checksum, wait for next mark, dropping other bytes.
// - Reception or record format error parks block in dead state until reset, no error code.
// - Bad record type or bad record checksum is a format error.
// - Extended record with length not two or nonzero offset is error.
// - Data record after extended segment above limit is a format error.
// - End record with nonzero length is a format error.
// - Record is mark, length, offset high/low, type, data, checksum.
// - Protected commands run only after password authentication, except on a blank part, where no password is checked.
// - Password is seven or more flash bytes inside permitted region.
// - Count address range check and length below minimum raise password error.
// - Compare start must not pass the limit N bytes below region top.
// - Mismatch or three identical in a row: password error, dead till reset.
// - Blank only when every top vector byte reads erased value.
// - Password error sends no error code bytes.
module bcp_core (
   input  wire        clk_sys_in,
   input  wire        rstn_in,
   input  wire        cmd_valid_in,
   input  wire [7:0]  cmd_code_in,
   input  wire        cmd_whole_in,
   input  wire [15:0] range_lo_in,
   input  wire [15:0] range_hi_in,
   input  wire        rx_valid_in,
   input  wire [7:0]  rx_data_in,
   input  wire        rx_err_in,
   input  wire        xfer_valid_in,
   input  wire [7:0]  xfer_data_in,
   input  wire        tx_ready_in,
   input  wire [7:0]  mem_rdata_in,
   output reg         mem_rd_out,
   output reg         mem_wr_out,
   output reg         mem_ram_out,
   output reg  [15:0] mem_addr_out,
   output reg  [7:0]  mem_wdata_out,
   output reg         tx_valid_out,
   output reg  [7:0]  tx_data_out,
   output reg  [15:0] sum_out,
   output reg         sum_valid_out,
   output reg         cmd_done_out,
   output reg         busy_out,
   output reg         blank_out,
   output reg         pw_err_out,
   output reg         fmt_err_out,
   output reg         dead_out
);
   localparam [3:0] S_IDLE = 4'h0, S_ADDR = 4'h1, S_BLK  = 4'h2, S_NRD  = 4'h3;
   localparam [3:0] S_PWD  = 4'h4, S_DISP = 4'h5, S_HEX  = 4'h6, S_SCAN = 4'h7;
   localparam [3:0] S_IDS  = 4'h8, S_TXH  = 4'h9, S_TXL  = 4'hA, S_DEAD = 4'hB;

   reg  [3:0]  st;
   reg  [7:0]  code;
   reg         whole;
   reg  [47:0] addr_sr;
   reg  [2:0]  addr_cnt;
   reg  [7:0]  pw_n;
   reg  [7:0]  pw_i;
   reg  [7:0]  pw_byte;
   reg         pw_run;
   reg  [15:0] scan_ptr;
   reg  [15:0] scan_end;
   reg         scan_go;
   reg         rd_d1;
   reg  [15:0] ram_first;
   reg  [15:0] ram_last;
   reg         ram_any;
   reg  [4:0]  xfer_idx;
   reg  [4:0]  xfer_last;
   reg         hex_en;

   wire        hx_dat;
   wire [19:0] hx_addr;
   wire [7:0]  hx_byte;
   wire        hx_end;
   wire        hx_err;

   wire [23:0] cnt_addr  = addr_sr[47:24];
   wire [23:0] cmp_addr  = addr_sr[23:0];
   wire        scan_idle = !scan_go && !mem_rd_out && !rd_d1;
   wire [4:0]  xfer_pos  = xfer_idx + 5'h01;
   wire [23:0] cmp_limit = blank_out ? `BCP_PW_HI : (`BCP_PW_HI - {16'h0000, mem_rdata_in});
   wire        protect   = (cmd_code_in == `BCP_CMD_ERASE) || (cmd_code_in == `BCP_CMD_READ) ||
                           (cmd_code_in == `BCP_CMD_RAM) || (cmd_code_in == `BCP_CMD_SECURE) ||
                           (cmd_code_in == `BCP_CMD_WRITE && !cmd_whole_in);

   // ========================================================================
   // Record parser, enabled only while loading
   bcp_hex_rec u_hex (
      .clk_sys_in    (clk_sys_in),
      .rstn_in       (rstn_in),
      .en_in         (hex_en),
      .rx_valid_in   (rx_valid_in),
      .rx_data_in    (rx_data_in),
      .dat_valid_out (hx_dat),
      .dat_addr_out  (hx_addr),
      .dat_byte_out  (hx_byte),
      .end_out       (hx_end),
      .err_out       (hx_err)
   );

   // ========================================================================
   // Status flags trail the state by one cycle
   always @(posedge clk_sys_in) begin
      if (!rstn_in) begin
         busy_out <= 1'b0;
         dead_out <= 1'b0;
         rd_d1    <= 1'b0;
      end else begin
         busy_out <= (st != S_IDLE);
         dead_out <= (st == S_DEAD);
         rd_d1    <= mem_rd_out;
      end
   end

   // ========================================================================
   // Command sequencer, shared memory port and checksum accumulator
   always @(posedge clk_sys_in) begin
      if (!rstn_in) begin
         st            <= S_IDLE;
         code          <= 8'h00;
         whole         <= 1'b0;
         addr_sr       <= 48'h000000000000;
         addr_cnt      <= 3'h0;
         pw_n          <= 8'h00;
         pw_i          <= 8'h00;
         pw_byte       <= 8'h00;
         pw_run        <= 1'b0;
         scan_ptr      <= 16'h0000;
         scan_end      <= 16'h0000;
         scan_go       <= 1'b0;
         ram_first     <= 16'h0000;
         ram_last      <= 16'h0000;
         ram_any       <= 1'b0;
         xfer_idx      <= 5'h00;
         xfer_last     <= 5'h00;
         hex_en        <= 1'b0;
         mem_rd_out    <= 1'b0;
         mem_wr_out    <= 1'b0;
         mem_ram_out   <= 1'b0;
         mem_addr_out  <= 16'h0000;
         mem_wdata_out <= 8'h00;
         tx_valid_out  <= 1'b0;
         tx_data_out   <= 8'h00;
         sum_out       <= 16'h0000;
         sum_valid_out <= 1'b0;
         cmd_done_out  <= 1'b0;
         blank_out     <= 1'b0;
         pw_err_out    <= 1'b0;
         fmt_err_out   <= 1'b0;
      end else begin
         mem_rd_out    <= 1'b0;
         mem_wr_out    <= 1'b0;
         sum_valid_out <= 1'b0;
         cmd_done_out  <= 1'b0;
         // Range reader: one address per cycle until the end is issued
         if (scan_go) begin
            mem_rd_out   <= 1'b1;
            mem_addr_out <= scan_ptr;
            scan_ptr     <= scan_ptr + 16'h0001;
            if (scan_ptr == scan_end)
               scan_go <= 1'b0;
         end
         case (st)
            S_IDLE: if (cmd_valid_in) begin
               code        <= cmd_code_in;
               whole       <= cmd_whole_in;
               sum_out     <= 16'h0000;
               ram_any     <= 1'b0;
               addr_cnt    <= 3'h0;
               pw_i        <= 8'h00;
               pw_run      <= 1'b0;
               xfer_idx    <= 5'h00;
               mem_ram_out <= (cmd_code_in == `BCP_CMD_RAM);
               if (cmd_code_in == `BCP_CMD_ID) begin
                  xfer_last <= `BCP_ID_LAST;
                  st        <= S_IDS;
               end else if (cmd_code_in == `BCP_CMD_STATUS) begin
                  xfer_last <= `BCP_STATUS_LAST;
                  st        <= S_IDS;
               end else if (protect) begin
                  st <= S_ADDR;
               end else if (cmd_code_in == `BCP_CMD_WRITE) begin
                  // Sum output only: whole flash, no records
                  scan_ptr <= `BCP_FLASH_LO;
                  scan_end <= `BCP_FLASH_HI;
                  scan_go  <= 1'b1;
                  st       <= S_SCAN;
               end
            end
            // Count address then compare start, three bytes each
            S_ADDR: if (rx_err_in) begin
               st <= S_DEAD;
            end else if (rx_valid_in) begin
               addr_sr  <= {addr_sr[39:0], rx_data_in};
               addr_cnt <= addr_cnt + 3'h1;
               if (addr_cnt == `BCP_ADDR_BYTES - 3'h1) begin
                  blank_out <= 1'b1;
                  scan_ptr  <= `BCP_BLANK_LO;
                  scan_end  <= `BCP_FLASH_HI;
                  scan_go   <= 1'b1;
                  st        <= S_BLK;
               end
            end
            // Any non-erased vector byte makes the part non-blank
            S_BLK: begin
               if (rd_d1 && mem_rdata_in != `BCP_ERASED)
                  blank_out <= 1'b0;
               if (scan_idle) begin
                  if (cnt_addr < `BCP_PW_LO || cnt_addr > `BCP_PW_HI) begin
                     pw_err_out <= 1'b1;
                     st         <= S_DEAD;
                  end else begin
                     mem_rd_out   <= 1'b1;
                     mem_addr_out <= cnt_addr[15:0];
                     st           <= S_NRD;
                  end
               end
            end
            S_NRD: if (rd_d1) begin
               pw_n <= mem_rdata_in;
               if (!blank_out && mem_rdata_in < `BCP_PW_N_MIN) begin
                  pw_err_out <= 1'b1;
                  st         <= S_DEAD;
               end else if (cmp_addr < `BCP_PW_LO || cmp_addr > cmp_limit) begin
                  pw_err_out <= 1'b1;
                  st         <= S_DEAD;
               end else begin
                  st <= blank_out ? S_DISP : S_PWD;
               end
            end
            // Each received byte is checked against flash two cycles later
            S_PWD: begin
               if (pw_i == pw_n && scan_idle)
                  st <= S_DISP;
               if (rx_valid_in && pw_i != pw_n) begin
                  mem_rd_out   <= 1'b1;
                  mem_addr_out <= cmp_addr[15:0] + {8'h00, pw_i};
                  pw_byte      <= rx_data_in;
                  pw_i         <= pw_i + 8'h01;
                  pw_run       <= (pw_i != 8'h00 && rx_data_in == pw_byte);
                  if (pw_i != 8'h00 && rx_data_in == pw_byte && pw_run) begin
                     pw_err_out <= 1'b1;
                     st         <= S_DEAD;
                  end
               end
               if (rd_d1 && mem_rdata_in != pw_byte) begin
                  pw_err_out <= 1'b1;
                  st         <= S_DEAD;
               end
               if (rx_err_in)
                  st <= S_DEAD;
            end
            S_DISP: begin
               case (code)
                  `BCP_CMD_ERASE: begin
                     scan_ptr <= whole ? `BCP_FLASH_LO : range_lo_in;
                     scan_end <= whole ? `BCP_FLASH_HI : range_hi_in;
                     scan_go  <= 1'b1;
                     st       <= S_SCAN;
                  end
                  `BCP_CMD_READ: begin
                     scan_ptr <= range_lo_in;
                     scan_end <= range_hi_in;
                     scan_go  <= 1'b1;
                     st       <= S_SCAN;
                  end
                  `BCP_CMD_WRITE, `BCP_CMD_RAM: begin
                     hex_en <= 1'b1;
                     st     <= S_HEX;
                  end
                  default: begin
                     cmd_done_out <= 1'b1;
                     st           <= S_IDLE;
                  end
               endcase
            end
            // Records land in memory; framing never reaches the sum
            S_HEX: begin
               if (hx_dat) begin
                  mem_wr_out    <= 1'b1;
                  mem_addr_out  <= hx_addr[15:0];
                  mem_wdata_out <= hx_byte;
                  ram_last      <= hx_addr[15:0];
                  ram_any       <= 1'b1;
                  if (!ram_any)
                     ram_first <= hx_addr[15:0];
               end
               if (hx_end) begin
                  hex_en <= 1'b0;
                  if (code == `BCP_CMD_WRITE) begin
                     scan_ptr <= `BCP_FLASH_LO;
                     scan_end <= `BCP_FLASH_HI;
                     scan_go  <= 1'b1;
                     st       <= S_SCAN;
                  end else if (ram_any) begin
                     scan_ptr <= ram_first;
                     scan_end <= ram_last;
                     scan_go  <= 1'b1;
                     st       <= S_SCAN;
                  end else begin
                     st <= S_TXH;
                  end
               end
               if (hx_err) begin
                  fmt_err_out <= 1'b1;
                  st          <= S_DEAD;
               end
               if (rx_err_in)
                  st <= S_DEAD;
            end
            // Carries above bit 15 simply fall off
            S_SCAN: begin
               if (rd_d1)
                  sum_out <= sum_out + {8'h00, mem_rdata_in};
               if (scan_idle)
                  st <= S_TXH;
            end
            S_IDS: if (xfer_valid_in) begin
               xfer_idx <= xfer_pos;
               if (xfer_pos >= `BCP_XFER_FIRST && xfer_pos <= xfer_last)
                  sum_out <= sum_out + {8'h00, xfer_data_in};
               if (xfer_pos == xfer_last)
                  st <= S_TXH;
            end
            // High byte goes out first
            S_TXH: begin
               if (!tx_valid_out) begin
                  tx_valid_out  <= 1'b1;
                  tx_data_out   <= sum_out[15:8];
                  sum_valid_out <= 1'b1;
               end else if (tx_ready_in) begin
                  tx_data_out <= sum_out[7:0];
                  st          <= S_TXL;
               end
            end
            S_TXL: if (tx_ready_in) begin
               tx_valid_out <= 1'b0;
               cmd_done_out <= 1'b1;
               hex_en       <= 1'b0;
               st           <= S_IDLE;
            end
            // Stays here until reset; nothing is sent
            S_DEAD: begin
               hex_en  <= 1'b0;
               scan_go <= 1'b0;
            end
            default: st <= S_DEAD;
         endcase
      end
   end
endmodule // bcp_core

// File: hw/bcp_map.vh
// Purpose: Constants for the boot checksum, hex record and password block
// Assumes: Included by bare name from the design files under hw/
// Notes:   Definitions only, guarded against double inclusion
`ifndef BCP_MAP_VH
`define BCP_MAP_VH

// ==========================================================================
// Command codes
`define BCP_CMD_ERASE    8'hF0
`define BCP_CMD_WRITE    8'h30
`define BCP_CMD_READ     8'h40
`define BCP_CMD_RAM      8'h60
`define BCP_CMD_ID       8'hC0
`define BCP_CMD_STATUS   8'hC3
`define BCP_CMD_SECURE   8'hFA

// ==========================================================================
// Address ranges
`define BCP_FLASH_LO     16'hC000
`define BCP_FLASH_HI     16'hFFFF
`define BCP_BLANK_LO     16'hFFE0
`define BCP_PW_LO        24'h00C000
`define BCP_PW_HI        24'h00FEFF
`define BCP_ERASED       8'hFF

// ==========================================================================
// Password limits
`define BCP_PW_N_MIN     8'h07
`define BCP_ADDR_BYTES   3'h6

// ==========================================================================
// Transferred byte windows for identity and status output
`define BCP_XFER_FIRST   5'h09
`define BCP_ID_LAST      5'h12
`define BCP_STATUS_LAST  5'h0C

// ==========================================================================
// Hex record layout
`define BCP_REC_MARK     8'h3A
`define BCP_REC_DATA     8'h00
`define BCP_REC_END      8'h01
`define BCP_REC_EXT      8'h02
`define BCP_EXT_LEN      8'h02
`define BCP_END_LEN      8'h00
`define BCP_EXT_OFFSET   16'h0000
`define BCP_SEG_MAX      16'h2000

`endif

// File: hw/bcp_hex_rec.v
// Purpose: Binary hex record parser feeding data bytes with their addresses
// Assumes: Bytes arrive from logic on clk_sys_in, one per rx_valid_in pulse
// Notes:   Stops in a halt state on any format error until en_in drops
`timescale 1ns/1ps
`include "bcp_map.vh"

module bcp_hex_rec (
   input  wire        clk_sys_in,
   input  wire        rstn_in,
   input  wire        en_in,
   input  wire        rx_valid_in,
   input  wire [7:0]  rx_data_in,
   output reg         dat_valid_out,
   output reg  [19:0] dat_addr_out,
   output reg  [7:0]  dat_byte_out,
   output reg         end_out,
   output reg         err_out
);
   localparam [2:0] H_MARK = 3'h0, H_LEN = 3'h1, H_OFFH = 3'h2, H_OFFL = 3'h3;
   localparam [2:0] H_TYPE = 3'h4, H_DATA = 3'h5, H_SUM  = 3'h6, H_HALT = 3'h7;

   reg  [2:0]  st;
   reg  [7:0]  len;
   reg  [7:0]  cnt;
   reg  [7:0]  rtype;
   reg  [15:0] offset;
   reg  [15:0] seg;
   reg  [15:0] seg_new;
   reg  [7:0]  sum;
   wire [7:0]  sum_in = sum + rx_data_in;

   // ========================================================================
   // Record walk; record sum covers every field after the mark
   always @(posedge clk_sys_in) begin
      if (!rstn_in || !en_in) begin
         st            <= H_MARK;
         len           <= 8'h00;
         cnt           <= 8'h00;
         rtype         <= 8'h00;
         offset        <= 16'h0000;
         seg           <= 16'h0000;
         seg_new       <= 16'h0000;
         sum           <= 8'h00;
         dat_valid_out <= 1'b0;
         dat_addr_out  <= 20'h00000;
         dat_byte_out  <= 8'h00;
         end_out       <= 1'b0;
         err_out       <= 1'b0;
      end else begin
         dat_valid_out <= 1'b0;
         end_out       <= 1'b0;
         err_out       <= 1'b0;
         if (rx_valid_in) begin
            case (st)
               // Anything but the mark between records is dropped
               H_MARK: if (rx_data_in == `BCP_REC_MARK) begin
                  st  <= H_LEN;
                  sum <= 8'h00;
               end
               H_LEN: begin
                  len <= rx_data_in;
                  sum <= sum_in;
                  st  <= H_OFFH;
               end
               H_OFFH: begin
                  offset[15:8] <= rx_data_in;
                  sum          <= sum_in;
                  st           <= H_OFFL;
               end
               H_OFFL: begin
                  offset[7:0] <= rx_data_in;
                  sum         <= sum_in;
                  st          <= H_TYPE;
               end
               H_TYPE: begin
                  rtype <= rx_data_in;
                  sum   <= sum_in;
                  cnt   <= 8'h00;
                  if (rx_data_in > `BCP_REC_EXT) begin
                     st      <= H_HALT;
                     err_out <= 1'b1;
                  end else if (rx_data_in == `BCP_REC_EXT &&
                               (len != `BCP_EXT_LEN || offset != `BCP_EXT_OFFSET)) begin
                     st      <= H_HALT;
                     err_out <= 1'b1;
                  end else if (rx_data_in == `BCP_REC_END && len != `BCP_END_LEN) begin
                     st      <= H_HALT;
                     err_out <= 1'b1;
                  end else if (rx_data_in == `BCP_REC_DATA && seg > `BCP_SEG_MAX) begin
                     st      <= H_HALT;
                     err_out <= 1'b1;
                  end else begin
                     st <= (len == 8'h00) ? H_SUM : H_DATA;
                  end
               end
               H_DATA: begin
                  sum <= sum_in;
                  cnt <= cnt + 8'h01;
                  if (rtype == `BCP_REC_DATA) begin
                     dat_valid_out <= 1'b1;
                     dat_byte_out  <= rx_data_in;
                     dat_addr_out  <= {seg, 4'h0} + {4'h0, offset} + {12'h000, cnt};
                  end else if (cnt == 8'h00) begin
                     seg_new[15:8] <= rx_data_in;
                  end else begin
                     seg_new[7:0] <= rx_data_in;
                  end
                  if (cnt == len - 8'h01)
                     st <= H_SUM;
               end
               H_SUM: begin
                  // Two's complement check: total must come to zero
                  if (sum_in != 8'h00) begin
                     st      <= H_HALT;
                     err_out <= 1'b1;
                  end else begin
                     st <= H_MARK;
                     if (rtype == `BCP_REC_END)
                        end_out <= 1'b1;
                     if (rtype == `BCP_REC_EXT)
                        seg <= seg_new;
                  end
               end
               default: st <= H_HALT;
            endcase
         end
      end
   end
endmodule // bcp_hex_rec

// File: tb/bcp_chk.sv
// Purpose: Port checks for bcp_core
// Assumes: One clock, synchronous reset
// Notes:   Error states must stay silent
`timescale 1ns/1ps
module bcp_chk (
   input wire logic        clk_sys_in,
   input wire logic        rstn_in,
   input wire logic        tx_ready_in,
   input wire logic        tx_valid_out,
   input wire logic [7:0]  tx_data_out,
   input wire logic [15:0] sum_out,
   input wire logic        sum_valid_out,
   input wire logic        pw_err_out,
   input wire logic        fmt_err_out,
   input wire logic        dead_out
);
   default clocking @(posedge clk_sys_in); endclocking
   default disable iff (!rstn_in);
   // ==========================================
   // Checksum handover, high byte taken first
   sequence s_hi; sum_valid_out && tx_ready_in; endsequence
   a_hi_first: assert property (sum_valid_out |-> tx_valid_out && tx_data_out == sum_out[15:8]) else $error("hi");
   a_lo_next: assert property (s_hi |=> tx_valid_out && tx_data_out == $past(sum_out[7:0])) else $error("lo");
   a_tx_holds: assert property (tx_valid_out && !tx_ready_in |=> tx_valid_out && $stable(tx_data_out)) else $error("hold");
   a_sum_pulse: assert property (sum_valid_out |=> !sum_valid_out) else $error("pulse");
   // Errors never answer and park the block
   a_pw_silent: assert property (pw_err_out |-> !tx_valid_out) else $error("pw tx");
   a_fmt_silent: assert property (fmt_err_out |-> !tx_valid_out) else $error("fmt tx");
   a_dead_stays: assert property (dead_out |=> dead_out) else $error("dead");
   a_err_parks: assert property ($rose(pw_err_out || fmt_err_out) |-> ##[0:2] dead_out) else $error("park");
endmodule // bcp_chk
bind bcp_core bcp_chk u_chk (.clk_sys_in, .rstn_in, .tx_ready_in, .tx_valid_out, .tx_data_out, .sum_out,
   .sum_valid_out, .pw_err_out, .fmt_err_out, .dead_out);

// File: tb/bcp_mem_model.sv
// Purpose: Flash and RAM image behind bcp_core
// Assumes: Read data one cycle after strobe
// Notes:   Idle data is the inverse, never stale
`timescale 1ns/1ps
module bcp_mem_model (
   input  wire logic        clk_in,
   input  wire logic        rd_in,
   input  wire logic        wr_in,
   input  wire logic [15:0] addr_in,
   input  wire logic [7:0]  wdata_in,
   output logic      [7:0]  rdata_out
);
   logic [7:0] m [0:65535];
   integer     k;
   // ==========================================
   // Blank image: top vector area erased
   initial begin
      rdata_out = 8'h00;
      for (k = 0; k < 65536; k++) m[k] = (k >= 32'hFFE0) ? 8'hFF : k[7:0] ^ k[15:8];
   end
   // One space serves flash and RAM
   always @(posedge clk_in) begin
      if (wr_in) m[addr_in] <= wdata_in;
      rdata_out <= rd_in ? m[addr_in] : ~rdata_out;
   end
endmodule // bcp_mem_model

// File: tb/testbench.sv
// Purpose: Self-checking bench for bcp_core
// Assumes: Blank image until the last two cases
// Notes:   Ready toggles to stall the sender
`timescale 1ns/1ps
module testbench;
   typedef struct {logic [7:0] c; logic w; logic [15:0] lo, hi, e;} bcp_row_t;
   reg         clk_sys_in = 1'b0, rstn_in = 1'b0, cv = 1'b0, cw = 1'b0, rv = 1'b0, xv = 1'b0, tr = 1'b0;
   reg  [7:0]  cc = 8'h00, rd = 8'h00, xd = 8'h00;
   reg  [15:0] lo = 16'h0000, hi = 16'h0000;
   wire        mrd, mwr, sv, done, pwe, fme, dead, blk;
   wire [7:0]  mq, mw, txd;
   wire [15:0] ma, sum;
   integer     err_total = 0, checked = 0, i, k;
   bcp_row_t   rows [0:4];
   logic [7:0] hx [0:14] = '{8'h55, 8'h3A, 8'h02, 8'hC1, 8'h00, 8'h00, 8'hAA, 8'hBB, 8'hD8, 8'h3A, 8'h00,
                             8'h00, 8'h00, 8'h01, 8'hFF};
   bcp_core dut (.clk_sys_in(clk_sys_in), .rstn_in(rstn_in), .cmd_valid_in(cv), .cmd_code_in(cc),
      .cmd_whole_in(cw), .range_lo_in(lo), .range_hi_in(hi), .rx_valid_in(rv), .rx_data_in(rd), .rx_err_in(1'b0),
      .xfer_valid_in(xv), .xfer_data_in(xd), .tx_ready_in(tr), .mem_rdata_in(mq), .mem_rd_out(mrd),
      .mem_wr_out(mwr), .mem_ram_out(), .mem_addr_out(ma), .mem_wdata_out(mw), .tx_valid_out(), .tx_data_out(txd),
      .sum_out(sum), .sum_valid_out(sv), .cmd_done_out(done), .busy_out(), .blank_out(blk), .pw_err_out(pwe),
      .fmt_err_out(fme), .dead_out(dead));
   bcp_mem_model mem (.clk_in(clk_sys_in), .rd_in(mrd), .wr_in(mwr), .addr_in(ma), .wdata_in(mw), .rdata_out(mq));
   // ==========================================
   // Clock, and a ready that stalls every other cycle
   initial forever #2 clk_sys_in = ~clk_sys_in;
   always @(posedge clk_sys_in) tr <= ~tr;
   function [7:0] mv(input integer a);
      mv = (a >= 32'hFFE0) ? 8'hFF : a[7:0] ^ a[15:8];
   endfunction
   task finish_test;
      if (err_total == 0 && checked > 0) $display("verification passed");
      else $display("verification failed");
      $finish;
   endtask
   task cmp(input [15:0] got, exp);
      checked++;
      if (got !== exp) begin
         err_total++;
         $display("Error %0t: got %h want %h", $time, got, exp);
      end
   endtask
   task tick(input integer n);
      repeat (n) @(posedge clk_sys_in);
   endtask
   task rst;
      rstn_in <= 1'b0;
      tick(20);
      rstn_in <= 1'b1;
      tick(1);
   endtask
   // Gap first, so nothing is missed after the last byte
   task rx(input [7:0] b);
      tick(3);
      rv <= 1'b1;
      rd <= b;
      tick(1);
      rv <= 1'b0;
   endtask
   task start(input [7:0] c, input w, input [15:0] l, h, input [7:0] m);
      cv <= 1'b1;
      cc <= c;
      cw <= w;
      lo <= l;
      hi <= h;
      tick(1);
      cv <= 1'b0;
      if (c != 8'hC0 && c != 8'hC3 && !(c == 8'h30 && w)) begin
         for (k = 0; k < 6; k++) rx(k % 3 == 1 ? m : 8'h00);
         // Bytes sent during the blank scan are dropped, so wait it out
         tick(45);
         // Non-blank: count byte at C000 reads C0, so 192 string bytes
         if (mem.m[16'hFFE0] !== 8'hFF) for (k = 0; k < 192; k++) rx(mv(k + 49152));
      end
   endtask
   task run(input bcp_row_t r);
      start(r.c, r.w, r.lo, r.hi, 8'hC0);
      if (r.c == 8'h60) for (k = 0; k < 15; k++) rx(hx[k]);
      for (k = 1; k <= (r.c == 8'hC3 ? 12 : r.c == 8'hC0 ? 18 : 0); k++) begin
         xv <= 1'b0;
         tick(1);
         xv <= 1'b1;
         xd <= k[7:0] * 8'h1D;
         tick(1);
      end
      xv <= 1'b0;
      k = 0;
      while (sv !== 1'b1 && k < 70000) begin
         @(negedge clk_sys_in);
         k++;
      end
      cmp(sum, r.e);
      cmp({8'h00, txd}, {8'h00, r.e[15:8]});
      while (done !== 1'b1 && k < 70000) begin
         @(negedge clk_sys_in);
         k++;
      end
      if (k >= 70000) begin
         err_total++;
         finish_test;
      end
      tick(2);
   endtask
   // Rows first, then reset-bound error cases and a non-blank sector erase
   initial begin
      rows[0] = '{8'hC3, 1'b0, 16'h0000, 16'h0000, 16'h0000};
      rows[1] = '{8'hC0, 1'b0, 16'h0000, 16'h0000, 16'h0000};
      rows[2] = '{8'h30, 1'b1, 16'hC000, 16'hFFFF, 16'h0000};
      rows[3] = '{8'h40, 1'b0, 16'hC010, 16'hC02F, 16'h0000};
      rows[4] = '{8'h60, 1'b0, 16'h0000, 16'h0000, 16'h0165};
      for (i = 0; i < 4; i++)
         for (k = (i < 2 ? 9 : rows[i].lo); k <= (i < 2 ? 12 + 6 * i : rows[i].hi); k++)
            rows[i].e += (i < 2) ? {8'h00, k[7:0] * 8'h1D} : {8'h00, mv(k)};
      tick(20);
      rstn_in <= 1'b1;
      tick(1);
      for (i = 0; i < 5; i++) run(rows[i]);
      rst;
      start(8'h30, 1'b0, 16'h0000, 16'h0000, 8'hC0);
      for (k = 9; k < 15; k++) rx(k == 13 ? 8'h03 : k == 14 ? 8'hFD : hx[k]);
      tick(20);
      cmp({13'h0000, blk, fme, dead}, 16'h0007);
      rst;
      mem.m[16'hFFE0] = 8'h00;
      start(8'h40, 1'b0, 16'hC000, 16'hC00F, 8'hB0);
      tick(80);
      cmp({13'h0000, blk, pwe, dead}, 16'h0003);
      // Sector erase on a non-blank part: password first, then the range sum
      rst;
      rows[3].c = 8'hF0;
      run(rows[3]);
      finish_test;
   end
endmodule // testbench
